// ===== rtl/tcf_timer.sv
// Purpose: 16-bit timer capture register, compare/overflow flags, irq gating
// Assumes: APB slave, one timer tick per enabled clock while running
// Notes: 16-bit registers use a shared high-byte latch like the CPU bus
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ps
`include "tcf_regs.svh"
// Functional notes
// - Capture event copies counter value into capture register
// - Low-byte read latches high byte; both bytes from same instant
// - Capture register may be TOP in modes 8, 10, 12, 14
// - Bits 7, 6, 4, 3 of enable and flag registers read zero
// - Irq requested only when enable, global enable and flag set
// - Capture flag on capture, or on reaching TOP when capture is TOP
// - Flags clear on vector execution or write of one
// - Compare flags set one timer cycle after a match
// - Force-compare strobes never set compare flags
// - Overflow flag at overflow in normal and clear-on-match modes
// - Overflow at MAX, BOTTOM or TOP according to waveform mode
// - Capture pin disconnected when capture register is TOP
// - Edge select zero falling, one rising
// - Noise filter needs four equal samples
module tcf_timer (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // APB
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Capture sources and CPU interrupt side
   input wire logic i_capture_input_pin,
   input wire logic i_ac_out,
   input wire logic i_global_irq_en,
   input wire tcf_pkg::tcf_irq_t i_vector_ack,
   output tcf_pkg::tcf_irq_t o_irq_req,
   output logic o_irq
);
   import tcf_pkg::*;
   tcf_state_t s_q;
   tcf_state_t s_d;
   logic filt_level;
   logic ac_level;
   logic cap_src;
   logic cap_edge;
   logic icr_top;
   logic [15:0] top;
   logic tick;
   logic at_top;
   logic at_bot;
   logic ovf_ev;
   logic capt_ev;
   logic wr;
   logic rd;
   logic [7:0] w1c;
   logic [7:0] hw_set;
   logic [7:0] ack;
   logic [7:0] pend;
   logic phase_mode;
   logic fast_mode;

   tcf_filter u_filter (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_filt_en(s_q.filt_en),
      .i_pin(i_capture_input_pin),
      .o_level(filt_level)
   );

   // Comparator output is treated as asynchronous: same synchroniser, filter off
   tcf_filter u_ac_filter (
      .i_mclk(i_mclk),
      .i_rst_n(i_rst_n),
      .i_ce(i_ce),
      .i_filt_en(1'b0),
      .i_pin(i_ac_out),
      .o_level(ac_level)
   );

   always_comb begin
      icr_top = 1'b0;
      top = `TCF_MAX;
      phase_mode = 1'b0;
      fast_mode = 1'b0;
      case (s_q.waveform_mode_field)
         4'h0: top = `TCF_MAX;
         4'h1: begin
            top = 16'h00ff;
            phase_mode = 1'b1;
         end
         4'h2: begin
            top = 16'h01ff;
            phase_mode = 1'b1;
         end
         4'h3: begin
            top = 16'h03ff;
            phase_mode = 1'b1;
         end
         4'h4: top = s_q.compare_a_value;
         4'h5: begin
            top = 16'h00ff;
            fast_mode = 1'b1;
         end
         4'h6: begin
            top = 16'h01ff;
            fast_mode = 1'b1;
         end
         4'h7: begin
            top = 16'h03ff;
            fast_mode = 1'b1;
         end
         4'h8: begin
            top = s_q.capture_value;
            icr_top = 1'b1;
            phase_mode = 1'b1;
         end
         4'h9: begin
            top = s_q.compare_a_value;
            phase_mode = 1'b1;
         end
         4'ha: begin
            top = s_q.capture_value;
            icr_top = 1'b1;
            phase_mode = 1'b1;
         end
         4'hb: begin
            top = s_q.compare_a_value;
            phase_mode = 1'b1;
         end
         4'hc: begin
            top = s_q.capture_value;
            icr_top = 1'b1;
         end
         4'he: begin
            top = s_q.capture_value;
            icr_top = 1'b1;
            fast_mode = 1'b1;
         end
         4'hf: begin
            top = s_q.compare_a_value;
            fast_mode = 1'b1;
         end
         // Reserved mode behaves as a free-running counter
         default: top = `TCF_MAX;
      endcase
   end

   assign cap_src = s_q.ac_src ? ac_level : filt_level;
   // Rising when select is one, falling when zero
   assign cap_edge = (cap_src != s_q.cap_prev) && (cap_src == s_q.edge_sel);
   assign tick = s_q.run;
   assign at_top = (s_q.counter_value == top);
   assign at_bot = (s_q.counter_value == `TCF_BOTTOM);
   assign capt_ev = icr_top ? (tick && at_top) : cap_edge;
   always_comb begin
      if (phase_mode) begin
         ovf_ev = tick && at_bot && (s_q.dir == TCF_DOWN);
      end else if (fast_mode) begin
         ovf_ev = tick && at_top;
      end else begin
         ovf_ev = tick && (s_q.counter_value == `TCF_MAX);
      end
   end

   // Register effects happen on the first access edge; pready follows one cycle later
   assign wr = i_psel && i_penable && !s_q.resp_due && i_pwrite;
   assign rd = i_psel && i_penable && !s_q.resp_due && !i_pwrite;
   assign w1c = (wr && i_paddr == `TCF_OFF_FLAGS) ? i_pwdata[7:0] : `TCF_RST_8;
   assign ack = {2'b00, i_vector_ack.capt, 2'b00, i_vector_ack.cmp_b, i_vector_ack.cmp_a,
                 i_vector_ack.ovf};
   // Force strobes take no part here; only latched real matches set compare flags
   assign hw_set = {2'b00, capt_ev, 2'b00, s_q.match_b_q, s_q.match_a_q, ovf_ev};

   always_comb begin
      s_d = s_q;
      s_d.pslverr = 1'b0;
      s_d.resp_due = i_psel && i_penable && !s_q.resp_due;
      s_d.cap_prev = cap_src;
      // Flags: clear by vector or write-one, then hardware set wins
      s_d.irq_flags = ((s_q.irq_flags & ~w1c & ~ack) | hw_set) & `TCF_IRQ_USED;
      if (capt_ev && !icr_top) begin
         s_d.capture_value = s_q.counter_value;
      end
      // Compare flag lands one timer cycle after the match
      s_d.match_a_q = tick && !s_q.blk && (s_q.counter_value == s_q.compare_a_value);
      s_d.match_b_q = tick && !s_q.blk && (s_q.counter_value == s_q.compare_b_value);
      s_d.blk = 1'b0;
      if (tick) begin
         if (phase_mode) begin
            if (s_q.dir == TCF_UP) begin
               if (at_top) begin
                  s_d.dir = TCF_DOWN;
                  s_d.counter_value = s_q.counter_value - 16'd1;
               end else begin
                  s_d.counter_value = s_q.counter_value + 16'd1;
               end
            end else if (at_bot) begin
               s_d.dir = TCF_UP;
               s_d.counter_value = s_q.counter_value + 16'd1;
            end else begin
               s_d.counter_value = s_q.counter_value - 16'd1;
            end
         end else if (at_top) begin
            s_d.counter_value = `TCF_BOTTOM;
         end else begin
            s_d.counter_value = s_q.counter_value + 16'd1;
         end
      end
      if (rd) begin
         s_d.prdata = '0;
         case (i_paddr)
            `TCF_OFF_CAPTURE: begin
               s_d.prdata = {24'h0, s_q.capture_value[7:0]};
               s_d.temp = s_q.capture_value[15:8];
            end
            `TCF_OFF_COUNTER: begin
               s_d.prdata = {24'h0, s_q.counter_value[7:0]};
               s_d.temp = s_q.counter_value[15:8];
            end
            `TCF_OFF_CMP_A: s_d.prdata = {24'h0, s_q.compare_a_value[7:0]};
            `TCF_OFF_CMP_B: s_d.prdata = {24'h0, s_q.compare_b_value[7:0]};
            `TCF_OFF_TEMP: s_d.prdata = {24'h0, s_q.temp};
            `TCF_OFF_ENABLE: s_d.prdata = {24'h0, s_q.irq_en & `TCF_IRQ_USED};
            `TCF_OFF_FLAGS: s_d.prdata = {24'h0, s_q.irq_flags & `TCF_IRQ_USED};
            `TCF_OFF_CONTROL: s_d.prdata = {24'h0, s_q.run, s_q.ac_src, s_q.filt_en,
                                            s_q.edge_sel, s_q.waveform_mode_field};
            default: s_d.pslverr = 1'b1;
         endcase
      end
      if (wr) begin
         case (i_paddr)
            `TCF_OFF_CAPTURE: s_d.capture_value = {s_q.temp, i_pwdata[7:0]};
            `TCF_OFF_COUNTER: begin
               s_d.counter_value = {s_q.temp, i_pwdata[7:0]};
               s_d.blk = 1'b1;
               s_d.match_a_q = 1'b0;
               s_d.match_b_q = 1'b0;
            end
            `TCF_OFF_CMP_A: s_d.compare_a_value = {s_q.temp, i_pwdata[7:0]};
            `TCF_OFF_CMP_B: s_d.compare_b_value = {s_q.temp, i_pwdata[7:0]};
            `TCF_OFF_TEMP: s_d.temp = i_pwdata[7:0];
            `TCF_OFF_ENABLE: s_d.irq_en = i_pwdata[7:0] & `TCF_IRQ_USED;
            `TCF_OFF_FLAGS: s_d.irq_flags = s_d.irq_flags;
            `TCF_OFF_CONTROL: begin
               s_d.waveform_mode_field = i_pwdata[`TCF_CTL_WGM_LSB +: 4];
               s_d.edge_sel = i_pwdata[`TCF_CTL_EDGE];
               s_d.filt_en = i_pwdata[`TCF_CTL_FILT];
               s_d.ac_src = i_pwdata[`TCF_CTL_ACSRC];
               s_d.run = i_pwdata[`TCF_CTL_RUN];
               // Force strobes are write-only and touch no flag
            end
            default: s_d.pslverr = 1'b1;
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         s_q <= '0;
         s_q.dir <= TCF_UP;
      end else if (i_ce) begin
         s_q <= s_d;
      end
   end

   assign pend = s_q.irq_flags & s_q.irq_en;
   assign o_irq_req.capt = i_global_irq_en && pend[`TCF_BIT_CAPT];
   assign o_irq_req.cmp_b = i_global_irq_en && pend[`TCF_BIT_CMPB];
   assign o_irq_req.cmp_a = i_global_irq_en && pend[`TCF_BIT_CMPA];
   assign o_irq_req.ovf = i_global_irq_en && pend[`TCF_BIT_OVF];
   assign o_irq = |o_irq_req;
   assign o_prdata = s_q.prdata;
   assign o_pslverr = s_q.pslverr;
   // One wait state: answer registered at the access edge
   assign o_pready = i_psel && i_penable && s_q.resp_due && i_ce;
endmodule // tcf_timer

// ===== rtl/tcf_regs.svh
// Purpose: Register offsets, field positions, reset values and timing counts
// Assumes: APB with 32-bit data, one register per aligned word
// Notes: Included by the package users; definitions only
`ifndef TCF_REGS_SVH
`define TCF_REGS_SVH
// Byte offsets
`define TCF_OFF_CAPTURE 12'h000
`define TCF_OFF_ENABLE 12'h004
`define TCF_OFF_FLAGS 12'h008
`define TCF_OFF_CONTROL 12'h00c
`define TCF_OFF_COUNTER 12'h010
`define TCF_OFF_CMP_A 12'h014
`define TCF_OFF_CMP_B 12'h018
`define TCF_OFF_TEMP 12'h01c
// Flag / enable bit positions
`define TCF_BIT_CAPT 5
`define TCF_BIT_CMPB 2
`define TCF_BIT_CMPA 1
`define TCF_BIT_OVF 0
`define TCF_IRQ_USED 8'h27
// Control field positions
`define TCF_CTL_WGM_LSB 0
`define TCF_CTL_EDGE 4
`define TCF_CTL_FILT 5
`define TCF_CTL_ACSRC 6
`define TCF_CTL_RUN 7
`define TCF_CTL_FOCA 8
`define TCF_CTL_FOCB 9
// Reset values
`define TCF_RST_16 16'h0000
`define TCF_RST_8 8'h00
// Noise filter: successive equal samples required
`define TCF_FILT_SAMPLES 4
`define TCF_FILT_CNT_W 2
`define TCF_MAX 16'hffff
`define TCF_BOTTOM 16'h0000
`endif

// ===== rtl/tcf_pkg.sv
// Purpose: Types for the timer capture and interrupt flag block
// Assumes: Constants live in tcf_regs.svh
// Notes: One-hot direction state and packed state records
package tcf_pkg;
   typedef enum logic [1:0] {
      TCF_UP = 2'b01,
      TCF_DOWN = 2'b10
   } tcf_dir_t;

   typedef struct packed {
      logic [2:0] sync;
      logic [1:0] cnt;
      logic filt;
   } tcf_filt_st_t;

   typedef struct packed {
      logic capt;
      logic cmp_b;
      logic cmp_a;
      logic ovf;
   } tcf_irq_t;

   typedef struct packed {
      logic [15:0] capture_value;
      logic [15:0] counter_value;
      logic [15:0] compare_a_value;
      logic [15:0] compare_b_value;
      logic [7:0] temp;
      logic [7:0] irq_en;
      logic [7:0] irq_flags;
      logic [3:0] waveform_mode_field;
      logic edge_sel;
      logic filt_en;
      logic ac_src;
      logic run;
      tcf_dir_t dir;
      logic match_a_q;
      logic match_b_q;
      logic blk;
      logic cap_prev;
      logic [31:0] prdata;
      logic pslverr;
      logic resp_due;
   } tcf_state_t;
endpackage

// ===== rtl/tcf_filter.sv
// Purpose: Capture input synchroniser with optional noise filter
// Assumes: Pin is asynchronous to i_mclk
// Notes: Three flops; with the filter off a change is accepted when the last two agree, with it on after three agreeing cycles
`timescale 1ns/1ps
`include "tcf_regs.svh"
module tcf_filter (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // Control
   input wire logic i_filt_en,
   // Pin
   input wire logic i_pin,
   // Filtered level
   output logic o_level
);
   import tcf_pkg::*;
   tcf_filt_st_t st_q;
   tcf_filt_st_t st_d;

   always_comb begin
      st_d = st_q;
      st_d.sync = {st_q.sync[1:0], i_pin};
      // Only sync[1] and sync[2] are compared; sync[0] feeds sync[1] alone
      if (st_q.sync[2] != st_q.sync[1]) begin
         st_d.cnt = '0;
      end else if (st_q.sync[2] == st_q.filt) begin
         st_d.cnt = '0;
      end else if (!i_filt_en) begin
         st_d.filt = st_q.sync[2];
         st_d.cnt = '0;
      end else if (st_q.cnt == `TCF_FILT_CNT_W'(`TCF_FILT_SAMPLES - 2)) begin
         st_d.filt = st_q.sync[2];
         st_d.cnt = '0;
      end else begin
         st_d.cnt = st_q.cnt + 2'd1;
      end
   end

   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         st_q <= '0;
      end else if (i_ce) begin
         st_q <= st_d;
      end
   end

   assign o_level = st_q.filt;
endmodule // tcf_filter

// ===== bench/tcf_timer_properties.sv
// Purpose: Port-level checks for the timer capture and flag block
// Assumes: APB with one wait state; read data and error stand with pready
// Notes: Attached by the bind at the foot
`timescale 1ns/1ps
module tcf_timer_properties (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   // APB
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [11:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic o_pready,
   input wire logic o_pslverr,
   // Capture and interrupt side
   input wire logic i_capture_input_pin,
   input wire logic i_ac_out,
   input wire logic i_global_irq_en,
   input wire tcf_pkg::tcf_irq_t i_vector_ack,
   input wire tcf_pkg::tcf_irq_t o_irq_req,
   input wire logic o_irq
);
   import tcf_pkg::*;
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   logic acc;
   logic [3:0] en_w;
   assign acc = i_psel && i_penable && o_pready;
   assign en_w = {i_pwdata[5], i_pwdata[2], i_pwdata[1], i_pwdata[0]};
   property p_ready;
      o_pready |-> i_psel && i_penable && i_ce;
   endproperty
   a_ready: assert property (p_ready) else $error("pready outside an access phase");
   property p_wait;
      i_psel && i_penable && i_ce && !o_pready |=> o_pready || !i_ce;
   endproperty
   a_wait: assert property (p_wait) else $error("pready not after one wait state");
   property p_rsv;
      acc && !i_pwrite && (i_paddr == 12'h004 || i_paddr == 12'h008)
      |-> o_prdata[31:6] == 26'h0 && o_prdata[4:3] == 2'h0;
   endproperty
   a_rsv: assert property (p_rsv) else $error("unused bits read nonzero");
   property p_gate;
      !i_global_irq_en |-> !(|o_irq_req);
   endproperty
   a_gate: assert property (p_gate) else $error("request without global enable");
   property p_or;
      o_irq == (|o_irq_req);
   endproperty
   a_or: assert property (p_or) else $error("irq differs from requests");
   property p_en_w;
      acc && i_pwrite && i_paddr == 12'h004 |=> (o_irq_req & ~$past(en_w)) == 4'h0;
   endproperty
   a_en_w: assert property (p_en_w) else $error("request with enable off");
   property p_w1c;
      acc && i_pwrite && i_paddr == 12'h008 && i_pwdata[5] |=> !o_irq_req.capt;
   endproperty
   a_w1c: assert property (p_w1c) else $error("capture flag not cleared");
   property p_w0;
      acc && i_pwrite && i_paddr == 12'h008 && !i_pwdata[0] && o_irq_req.ovf
      && !i_vector_ack.ovf |=> o_irq_req.ovf || !i_global_irq_en;
   endproperty
   a_w0: assert property (p_w0) else $error("zero write cleared a flag");
   property p_ack;
      |i_vector_ack |=> (o_irq_req & $past(i_vector_ack)) == 4'h0;
   endproperty
   a_ack: assert property (p_ack) else $error("vector did not clear flag");
   property p_err;
      acc && i_paddr > 12'h01c |-> o_pslverr;
   endproperty
   a_err: assert property (p_err) else $error("no error on unmapped access");
   c_irq: cover property ($rose(o_irq));
   c_ack: cover property (|i_vector_ack);
   c_w1c: cover property (acc && i_pwrite && i_paddr == 12'h008 && o_irq_req.capt);
endmodule // tcf_timer_properties
bind tcf_timer tcf_timer_properties i_tcf_timer_properties (.i_mclk(i_mclk),
   .i_rst_n(i_rst_n), .i_ce(i_ce), .i_psel(i_psel), .i_penable(i_penable),
   .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata),
   .o_pready(o_pready), .o_pslverr(o_pslverr), .i_capture_input_pin(i_capture_input_pin),
   .i_ac_out(i_ac_out), .i_global_irq_en(i_global_irq_en), .i_vector_ack(i_vector_ack),
   .o_irq_req(o_irq_req), .o_irq(o_irq));

// ===== bench/tcf_cpu_model.sv
// Purpose: CPU side that executes interrupt vectors
// Assumes: One vector at a time, lowest source first
// Notes: Busy holds off vectors so flags can be seen standing
`timescale 1ns/1ps
module tcf_cpu_model (
   // Clock and reset
   input wire logic i_mclk,
   input wire logic i_rst_n,
   // Behaviour
   input wire logic i_busy,
   input wire logic i_slow,
   // Interrupt side
   input wire tcf_pkg::tcf_irq_t i_irq_req,
   output tcf_pkg::tcf_irq_t o_vector_ack
);
   import tcf_pkg::*;
   logic [3:0] wait_q;
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wait_q <= 4'h0;
         o_vector_ack <= '0;
      end else if (|o_vector_ack || !(|i_irq_req) || i_busy) begin
         // Re-arm only after the pulse, so a flag is never acked twice
         wait_q <= 4'h0;
         o_vector_ack <= '0;
      end else if (wait_q < (i_slow ? 4'hc : 4'h1)) begin
         wait_q <= wait_q + 4'h1;
      end else begin
         o_vector_ack <= tcf_irq_t'(i_irq_req & ~(i_irq_req - 4'h1));
      end
   end
endmodule // tcf_cpu_model

// ===== bench/tcf_timer_tb_top.sv
// Purpose: Self-checking bench for the timer capture and flag block
// Assumes: APB with one wait state; read data taken at the pready edge
// Notes: Read notes are queued and compared by a separate watcher
`timescale 1ns/1ps
module tcf_timer_tb_top;
   import tcf_pkg::*;
   logic i_mclk = 0, i_rst_n = 0, psel = 0, pen = 0, pwr = 0, pin = 0;
   logic gie = 0, busy = 0, slow = 0, acmp = 0, rdy, err, irq;
   logic [11:0] padr = '0;
   logic [31:0] pwd = '0, lfsr = 32'h3e08b1a0, prd;
   logic [15:0] cv = '0;
   logic [31:0] expq[$], mskq[$];
   logic [7:0] ctab[6] = '{8'h10, 8'h00, 8'h30, 8'h30, 8'h1c, 8'h50};
   int ltab[6] = '{8, 8, 2, 8, 8, 8};
   logic ktab[6] = '{1, 1, 0, 1, 0, 1};
   logic [7:0] otab[3] = '{8'h80, 8'h85, 8'h81};
   logic [15:0] vtab[3] = '{16'hfff0, 16'h00f0, 16'h00f0};
   int fails = 0, cmp_count = 0;
   tcf_irq_t req, ack;
   always #5 i_mclk = ~i_mclk;
   tcf_timer i_tcf_timer (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_ce(1'b1), .i_psel(psel),
      .i_penable(pen), .i_pwrite(pwr), .i_paddr(padr), .i_pwdata(pwd), .o_prdata(prd),
      .o_pready(rdy), .o_pslverr(err), .i_capture_input_pin(pin), .i_ac_out(acmp),
      .i_global_irq_en(gie), .i_vector_ack(ack), .o_irq_req(req), .o_irq(irq));
   tcf_cpu_model i_tcf_cpu_model (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_busy(busy),
      .i_slow(slow), .i_irq_req(req), .o_vector_ack(ack));
   function automatic logic [31:0] nxt(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic print_verdict();
      $display("counts cmp_count %0d fails %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask
   task automatic tmo();
      fails++;
      $display("wrong value timeout expected %h seen %h", 1'b1, 1'b0);
      print_verdict();
   endtask
   task automatic apb(input logic [11:0] a, input logic [31:0] d, input logic w);
      int n;
      n = 0;
      @(posedge i_mclk);
      psel <= 1;
      padr <= a;
      pwd <= d;
      pwr <= w;
      @(posedge i_mclk);
      pen <= 1;
      @(posedge i_mclk);
      while (rdy !== 1'b1 && n < 50) begin
         @(posedge i_mclk);
         n++;
      end
      if (rdy !== 1'b1)
         tmo();
      psel <= 0;
      pen <= 0;
   endtask
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(a, d, 1'b1);
   endtask
   task automatic wr16(input logic [11:0] a, input logic [15:0] v);
      wr(12'h01c, {24'h0, v[15:8]});
      wr(a, {24'h0, v[7:0]});
   endtask
   task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
      expq.push_back(e);
      mskq.push_back(m);
      apb(a, 32'h0, 1'b0);
   endtask
   task automatic wait_irq(input logic lv);
      int n;
      n = 0;
      while (irq !== lv && n < 500) begin
         @(posedge i_mclk);
         n++;
      end
      if (irq !== lv)
         tmo();
   endtask
   // Read data and error stand while pready is high
   always @(posedge i_mclk) begin
      if (psel && pen && rdy === 1'b1 && !pwr) begin
         cmp_count++;
         if ((prd & mskq[0]) !== expq[0]) begin
            fails++;
            $display("wrong value prdata expected %h seen %h", expq[0], prd & mskq[0]);
         end
         if (err !== (padr > 12'h01c)) begin
            fails++;
            $display("wrong value pslverr expected %h seen %h", padr > 12'h01c, err);
         end
         void'(expq.pop_front());
         void'(mskq.pop_front());
      end
   end
   initial begin
      repeat (12) @(posedge i_mclk);
      i_rst_n <= 1;
      for (int i = 0; i < 3; i++) rd(12'(4 * i), 32'h0, 32'hffffffff);
      rd(12'h020, 32'h0, 32'hffffffff);
      repeat (4) begin
         lfsr = nxt(lfsr);
         wr(12'h004, lfsr);
         rd(12'h004, lfsr & 32'h27, 32'hffffffff);
      end
      $display("test registers done");
      wr16(12'h010, 16'h0010);
      wr16(12'h014, 16'h0040);
      wr16(12'h018, 16'h0030);
      wr(12'h00c, 32'h300);
      rd(12'h008, 32'h0, 32'h6);
      wr(12'h004, 32'h2);
      gie <= 1;
      wr(12'h00c, 32'h80);
      wait_irq(1);
      wait_irq(0);
      rd(12'h008, 32'h4, 32'h6);
      slow <= 1;
      wr(12'h004, 32'h4);
      wait_irq(1);
      wait_irq(0);
      $display("test compare done");
      busy <= 1;
      wr(12'h004, 32'h21);
      // Overflow point per mode; stopped first so the clear is not raced
      for (int i = 0; i < 3; i++) begin
         wr(12'h00c, {24'h0, otab[i] & 8'h7f});
         wr16(12'h010, vtab[i]);
         wr(12'h008, 32'h27);
         rd(12'h008, 32'h0, 32'h1);
         wr(12'h00c, {24'h0, otab[i]});
         repeat (30) @(posedge i_mclk);
         rd(12'h008, {31'h0, i < 2}, 32'h1);
         repeat (270) @(posedge i_mclk);
         rd(12'h008, 32'h1, 32'h1);
      end
      wr(12'h008, 32'h0);
      rd(12'h008, 32'h1, 32'h1);
      wr(12'h008, 32'h1);
      rd(12'h008, 32'h0, 32'h1);
      $display("test overflow done");
      // Counter is stopped before it is loaded, so the captured value is exact
      for (int i = 0; i < 6; i++) begin
         lfsr = nxt(lfsr);
         wr(12'h00c, {24'h0, ctab[i]});
         wr16(12'h010, lfsr[15:0]);
         @(posedge i_mclk);
         if (ctab[i][6])
            acmp <= 1;
         else
            pin <= 1;
         repeat (ltab[i]) @(posedge i_mclk);
         pin <= 0;
         acmp <= 0;
         repeat (12) @(posedge i_mclk);
         if (ktab[i])
            cv = lfsr[15:0];
         rd(12'h000, {24'h0, cv[7:0]}, 32'hff);
         rd(12'h01c, {24'h0, cv[15:8]}, 32'hff);
      end
      wr(12'h00c, 32'h0);
      rd(12'h008, 32'h20, 32'h20);
      wr(12'h008, 32'h20);
      rd(12'h008, 32'h0, 32'h20);
      wr16(12'h000, 16'h0020);
      wr16(12'h010, 16'h0000);
      wr(12'h00c, 32'h8c);
      repeat (40) @(posedge i_mclk);
      wr(12'h00c, 32'h0);
      rd(12'h008, 32'h20, 32'h20);
      $display("test capture done");
      repeat (4) @(posedge i_mclk);
      print_verdict();
   end
endmodule // tcf_timer_tb_top
